// File: dv/iwt_independent_watchdog_bench.sv
// Self-checking bench for the independent watchdog timer
`timescale 1ns/1ps
module iwt_independent_watchdog_bench;
  import iwt_pkg::*;
  `define CHK(got, exp) \
    begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
        miscompares++; \
        $display("[FAIL] %0t mismatch", $time); \
      end \
    end
  // ****************************************
  // Stimulus and design
  // ****************************************
  logic             mclk = 1'b0;
  logic             resetn = 1'b0;
  logic             opt_hw_start = 1'b0;
  logic             sw_start = 1'b0;
  logic             refresh = 1'b0;
  logic             timer_mode = 1'b0;
  logic [PRE_W-1:0] prescale_div = 8'h02;
  logic [CNT_W-1:0] reload_value = 12'h005;
  logic [CNT_W-1:0] window_value = 12'hFFF;
  logic             dbg_halt = 1'b0;
  logic             dbg_freeze_en = 1'b0;
  logic             running;
  logic [CNT_W-1:0] count;
  logic             timeout_pulse;
  logic             wdt_reset_req;
  int               miscompares = 0;
  int               n_tests = 0;
  int               n;
  logic [CNT_W-1:0] held;

  // 200 MHz clock
  initial begin
    forever #2.5 mclk = ~mclk;
  end

  // Short tick divider keeps a count step at 24 cycles
  iwt_independent_watchdog #(.LF_DIV(8)) dut (.mclk(mclk), .resetn(resetn), .opt_hw_start(opt_hw_start),
    .sw_start(sw_start), .refresh(refresh), .timer_mode(timer_mode), .prescale_div(prescale_div),
    .reload_value(reload_value), .window_value(window_value), .dbg_halt(dbg_halt),
    .dbg_freeze_en(dbg_freeze_en), .running(running), .count(count), .timeout_pulse(timeout_pulse),
    .wdt_reset_req(wdt_reset_req));

  // ****************************************
  // Shared tasks
  // ****************************************
  // Reset with strap and mode; first edge after release samples the strap
  task automatic do_reset(input logic hw, input logic tm);
    @(negedge mclk);
    resetn = 1'b0;
    opt_hw_start = hw;
    timer_mode = tm;
    repeat (5) @(negedge mclk);
    `CHK({running, count, timeout_pulse, wdt_reset_req}, {1'b0, CNT_RST, 2'b00})
    resetn = 1'b1;
    @(negedge mclk);
  endtask : do_reset

  // One-cycle pulses on the control inputs
  task automatic kick_start();
    sw_start = 1'b1;
    @(negedge mclk);
    sw_start = 1'b0;
  endtask : kick_start

  task automatic kick_refresh();
    refresh = 1'b1;
    @(negedge mclk);
    refresh = 1'b0;
  endtask : kick_refresh

  // Bounded wait for the next counter step; n is cycles waited
  task automatic wait_change();
    logic [CNT_W-1:0] c0;
    c0 = count;
    n = 0;
    while (count === c0 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_change

  // ****************************************
  // Scenarios
  // ****************************************
  // Strap start versus software start
  task automatic t_start();
    do_reset(1'b1, 1'b0);
    `CHK({running, count}, {1'b1, 12'h005})
    do_reset(1'b0, 1'b0);
    `CHK(running, 1'b0)
    kick_start();
    `CHK({running, count}, {1'b1, 12'h005})
    $display("t_start done");
  endtask : t_start

  // Step spacing, refresh reload, no way to stop
  task automatic t_steps();
    do_reset(1'b0, 1'b0);
    kick_start();
    wait_change();
    wait_change();
    `CHK(n, 24)
    `CHK(count, 12'h003)
    kick_start();
    `CHK({running, count}, {1'b1, 12'h003})
    kick_refresh();
    `CHK({running, count}, {1'b1, 12'h005})
    $display("t_steps done");
  endtask : t_steps

  // Refresh inside and outside the window
  task automatic t_window();
    window_value = 12'h003;
    do_reset(1'b0, 1'b0);
    kick_start();
    wait_change();
    wait_change();
    kick_refresh();
    `CHK({count, wdt_reset_req}, {12'h005, 1'b0})
    kick_refresh();
    @(negedge mclk);
    `CHK({running, wdt_reset_req}, 2'b11)
    window_value = 12'hFFF;
    $display("t_window done");
  endtask : t_window

  // Expiry at zero, then timer-mode wrap without reset
  task automatic t_expire(input logic tm);
    do_reset(1'b0, tm);
    kick_start();
    for (int i = 0; i < 8 && count !== CNT_ZERO; i++) wait_change();
    `CHK(wdt_reset_req, 1'b0)
    @(negedge mclk);
    if (!tm) `CHK(wdt_reset_req, 1'b1)
    else begin
      for (n = 0; n < 40 && timeout_pulse !== 1'b1; n++) @(negedge mclk);
      `CHK({timeout_pulse, count, wdt_reset_req}, {1'b1, 12'h005, 1'b0})
      @(negedge mclk);
      `CHK(timeout_pulse, 1'b0)
      // Out-of-window refresh in timer mode: no reload and no reset
      wait_change();
      window_value = 12'h003;
      kick_refresh();
      `CHK({count, wdt_reset_req}, {12'h004, 1'b0})
      window_value = 12'hFFF;
    end
    $display("t_expire done");
  endtask : t_expire

  // Debug halt freezes the counter, resumes on release
  task automatic t_freeze();
    do_reset(1'b0, 1'b0);
    kick_start();
    dbg_halt = 1'b1;
    dbg_freeze_en = 1'b1;
    @(negedge mclk);
    held = count;
    repeat (100) @(negedge mclk);
    `CHK(count, held)
    dbg_halt = 1'b0;
    wait_change();
    `CHK(count, held - CNT_ONE)
    dbg_freeze_en = 1'b0;
    // Halt without the freeze enable must not stop the count
    dbg_halt = 1'b1;
    wait_change();
    `CHK(n, 24)
    `CHK(count, held - 12'h002)
    dbg_halt = 1'b0;
    $display("t_freeze done");
  endtask : t_freeze

  // Verdict and end of run
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    t_start();
    t_steps();
    t_window();
    t_expire(1'b0);
    t_expire(1'b1);
    t_freeze();
    close_out();
  end

  // Watchdog: whole run needs a few hundred cycles
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
endmodule : iwt_independent_watchdog_bench

// File: rtl/iwt_independent_watchdog.sv
// Independent watchdog: prescaler, 12-bit down-counter, refresh window
`timescale 1ns/1ps
// Behaviour
// RL1: 8-bit prescaler divides tick, decrements counter
// RL2: 12-bit down-counter, refresh only inside window
// RL3: Counts on its own 40 kHz tick
// RL4: Keeps counting in stop and standby; here the tick is divided down from mclk and runs only while mclk runs
// RL5: Watchdog mode drives device reset on fault
// RL6: Timer mode runs freely, timeout pulse only
// RL7: Option strap chooses hardware or software start
// RL8: Counter frozen during debug halt
// RL9: Reset at zero or early refresh; reload
// RL10: Once started, cannot be stopped
module iwt_independent_watchdog #(
  parameter int unsigned LF_DIV = iwt_pkg::LF_DIV_CYCLES
) (
  // Clock and reset
  input  wire logic                     mclk,
  input  wire logic                     resetn,
  // Option strap
  input  wire logic                     opt_hw_start,
  // Software control
  input  wire logic                     sw_start,
  input  wire logic                     refresh,
  input  wire logic                     timer_mode,
  input  wire logic [iwt_pkg::PRE_W-1:0] prescale_div,
  input  wire logic [iwt_pkg::CNT_W-1:0] reload_value,
  input  wire logic [iwt_pkg::CNT_W-1:0] window_value,
  // Debug
  input  wire logic                     dbg_halt,
  input  wire logic                     dbg_freeze_en,
  // Status and actions
  output logic                          running,
  output logic [iwt_pkg::CNT_W-1:0]     count,
  output logic                          timeout_pulse,
  output logic                          wdt_reset_req
);
  import iwt_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  iwt_state_t       state_reg;
  logic             strap_seen_reg;
  logic             mode_timer_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [CNT_W-1:0] count_reg;
  logic             timeout_reg;
  logic             lf_tick;
  logic             run;
  logic             freeze;
  logic             start_req;
  logic             pre_wrap;
  logic             in_window;
  logic             good_refresh;
  logic             bad_refresh;
  logic             fault;
  logic             timer_wrap;

  // ****************************************
  // Low-speed time base
  // ****************************************
  // Tick is divided down from mclk, so it stops whenever mclk is gated
  iwt_tick_gen #(
    .DIV (LF_DIV)
  ) u_tick (
    .mclk   (mclk),
    .resetn (resetn),
    .tick   (lf_tick)
  ); // see RL3 see RL4

  // ****************************************
  // Decode
  // ****************************************
  assign run          = (state_reg == IWT_RUN);
  assign freeze       = dbg_halt & dbg_freeze_en;               // see RL8
  assign start_req    = (state_reg == IWT_IDLE) & (sw_start | (!strap_seen_reg & opt_hw_start)); // see RL7
  assign pre_wrap     = run & lf_tick & !freeze & (pre_reg == prescale_div); // see RL1
  assign in_window    = (count_reg <= window_value);            // see RL2
  assign good_refresh = run & refresh & in_window;
  assign bad_refresh  = run & refresh & !in_window;
  // Early refresh only matters as a fault in watchdog mode
  assign fault        = run & !mode_timer_reg & ((count_reg == CNT_ZERO) | bad_refresh); // see RL9
  assign timer_wrap   = run & mode_timer_reg & pre_wrap & (count_reg == CNT_ZERO); // see RL6

  // Strap is sampled once, on the first edge after reset release
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      strap_seen_reg <= 1'b0;
    end else begin
      strap_seen_reg <= 1'b1;
    end
  end

  // ****************************************
  // Control state
  // ****************************************
  // No path back to idle: only resetn stops it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_reg      <= IWT_IDLE;
      mode_timer_reg <= 1'b0;
    end else begin
      case (state_reg)
        IWT_IDLE: begin
          if (start_req) begin
            state_reg      <= IWT_RUN;
            mode_timer_reg <= timer_mode;  // Mode locked at start
          end
        end
        IWT_RUN: begin
          if (fault) begin
            state_reg <= IWT_FIRED;        // see RL5 see RL10
          end
        end
        IWT_FIRED: state_reg <= IWT_FIRED;
        default:   state_reg <= IWT_IDLE;
      endcase
    end
  end

  // ****************************************
  // Prescaler
  // ****************************************
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre_reg <= PRE_RST;
    end else if (start_req || good_refresh) begin
      pre_reg <= PRE_RST;
    end else if (run && lf_tick && !freeze) begin
      pre_reg <= pre_wrap ? PRE_RST : pre_reg + PRE_W'(1); // see RL1
    end
  end

  // ****************************************
  // Down-counter
  // ****************************************
  // Refresh beats a decrement in the same cycle, so a late service still counts
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= CNT_RST;
    end else if (start_req || good_refresh || timer_wrap) begin
      count_reg <= reload_value;           // see RL9
    end else if (pre_wrap && count_reg != CNT_ZERO) begin
      count_reg <= count_reg - CNT_ONE;    // see RL2
    end
  end

  // Timer-mode expiry strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= timer_wrap;           // see RL6
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign running       = (state_reg != IWT_IDLE);
  assign count         = count_reg;
  assign timeout_pulse = timeout_reg;
  assign wdt_reset_req = (state_reg == IWT_FIRED); // see RL5

  // ****************************************
  // Assertions
  // ****************************************
  prescale_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    pre_wrap |-> lf_tick && pre_reg == prescale_div && !freeze)   // see RL1
    else $error("prescaler wrapped off tick or at wrong count");

  count_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    (pre_wrap && !refresh && count_reg != CNT_ZERO) |=> count_reg == $past(count_reg) - CNT_ONE) // see RL2
    else $error("counter did not step down by one");

  tick_spacing_a: assert property (@(posedge mclk) disable iff (!resetn)
    lf_tick |=> !lf_tick [*4])                                     // see RL3
    else $error("low-speed tick too frequent");

  reset_fire_a: assert property (@(posedge mclk) disable iff (!resetn)
    fault |=> wdt_reset_req && running)                            // see RL5
    else $error("fault did not raise device reset");

  timer_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    timer_wrap |=> timeout_pulse && !wdt_reset_req && count_reg == $past(reload_value)) // see RL6
    else $error("timer mode expiry wrong");

  hw_start_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!strap_seen_reg && opt_hw_start) |=> running)                 // see RL7
    else $error("strap did not start watchdog");

  freeze_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (freeze && run && !refresh) |=> $stable(count_reg) && $stable(pre_reg)) // see RL8
    else $error("counter moved during debug halt");

  refresh_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    good_refresh |=> count_reg == $past(reload_value) && pre_reg == PRE_RST) // see RL9
    else $error("valid refresh did not reload");

  early_refresh_a: assert property (@(posedge mclk) disable iff (!resetn)
    (bad_refresh && !mode_timer_reg) |=> wdt_reset_req)            // see RL9
    else $error("refresh outside window not punished");

  no_stop_a: assert property (@(posedge mclk) disable iff (!resetn)
    running |=> running)                                           // see RL10
    else $error("watchdog stopped after start");

  pulse_single_a: assert property (@(posedge mclk) disable iff (!resetn)
    timeout_pulse |=> !timeout_pulse)                              // see RL6
    else $error("timeout pulse longer than one cycle");

  timer_quiet_a: assert property (@(posedge mclk) disable iff (!resetn)
    (running && mode_timer_reg) |-> !wdt_reset_req)                // see RL6
    else $error("timer mode raised device reset");

  reset_sticky_a: assert property (@(posedge mclk) disable iff (!resetn)
    wdt_reset_req |=> wdt_reset_req && running)                    // see RL5
    else $error("device reset request dropped");

  // Before any start the counter must sit untouched at its reset value
  idle_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !running |-> count == CNT_RST && !timeout_pulse)               // see RL7
    else $error("counter moved before start");
endmodule : iwt_independent_watchdog

// File: rtl/iwt_pkg.sv
// Shared constants for the independent watchdog timer
package iwt_pkg;
  // ****************************************
  // Clocking
  // ****************************************
  localparam int unsigned MCLK_FREQ_HZ = 200_000_000;
  localparam int unsigned LF_FREQ_HZ   = 40_000;
  // Cycles of mclk per low-speed tick (5000)
  localparam int unsigned LF_DIV_CYCLES = MCLK_FREQ_HZ / LF_FREQ_HZ;

  // ****************************************
  // Widths and reset values
  // ****************************************
  localparam int unsigned PRE_W = 8;
  localparam int unsigned CNT_W = 12;
  localparam logic [PRE_W-1:0] PRE_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_RST = 12'hFFF;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 12'h001;

  // ****************************************
  // Control states
  // ****************************************
  typedef enum logic [1:0] {
    IWT_IDLE,
    IWT_RUN,
    IWT_FIRED
  } iwt_state_t;
endpackage : iwt_pkg

// File: rtl/iwt_tick_gen.sv
// Divider making a one-cycle enable at the low-speed watchdog rate
`timescale 1ns/1ps
module iwt_tick_gen #(
  parameter int unsigned DIV = 5000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Enable out
  output logic      tick
);
  localparam int unsigned DW = $clog2(DIV);
  localparam logic [DW-1:0] LAST = DW'(DIV - 1);

  logic [DW-1:0] div_reg;

  // Free-running modulo counter, never gated by any mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= '0;
    end else if (div_reg == LAST) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + DW'(1);
    end
  end

  assign tick = (div_reg == LAST);
endmodule : iwt_tick_gen
